/* File: common/lps_pkg.sv */
// Purpose: Shared constants and types for the light/proximity register bank.
// Assumes: 25 MHz core clock; I2C serial clock arrives as its own clock.
// Notes: Time figures are kept in their own unit; cycle counts derive from them.
package lps_pkg;
	localparam logic [6:0] I2C_ADDR = 7'h44;
	localparam logic [7:0] REG_ID = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h01;
	localparam logic [7:0] REG_INT = 8'h02;
	localparam logic [7:0] REG_PLO = 8'h03;
	localparam logic [7:0] REG_PHI = 8'h04;
	localparam logic [7:0] REG_LLO = 8'h05;
	localparam logic [7:0] REG_LMID = 8'h06;
	localparam logic [7:0] REG_LHI = 8'h07;
	localparam logic [7:0] REG_PRES = 8'h08;
	localparam logic [7:0] REG_LRLO = 8'h09;
	localparam logic [7:0] REG_LRHI = 8'h0A;
	localparam logic [7:0] REG_RANGE = 8'h0B;
	localparam logic [7:0] RST_CFG = 8'hBC;
	localparam logic [7:0] RST_INT = 8'h8B;
	localparam logic [7:0] RST_PLO = 8'h00;
	localparam logic [7:0] RST_PHI = 8'hFF;
	localparam logic [7:0] RST_LLO = 8'h00;
	localparam logic [7:0] RST_LMID = 8'hF0;
	localparam logic [7:0] RST_LHI = 8'hFF;
	localparam logic [2:0] RST_RANGE = 3'h0;
	localparam int INT_PFLAG = 7;
	localparam int INT_LFLAG = 3;
	localparam logic [4:0] PERS_ONE = 5'h01;
	localparam logic [4:0] PERS_FOUR = 5'h04;
	localparam logic [4:0] PERS_EIGHT = 5'h08;
	localparam logic [4:0] PERS_MAX = 5'h10;
	localparam int CLK_MHZ = 25;
	localparam int PROX_MEAS_US = 540;
	localparam int SLEEP_TICK_US = 12500;
	localparam int LIGHT_PERIOD_MS = 100;
	localparam int PROX_MEAS_CYC = PROX_MEAS_US * CLK_MHZ;
	localparam int SLEEP_TICK_CYC = SLEEP_TICK_US * CLK_MHZ;
	localparam int LIGHT_PERIOD_CYC = LIGHT_PERIOD_MS * 1000 * CLK_MHZ;

	typedef logic [7:0] lps_byte_t;
	typedef struct packed {
		logic prox_enable;
		logic [2:0] prox_sleep_select;
		logic emitter_drive_select;
		logic light_enable;
		logic [1:0] spare;
	} lps_cfg_s;
	typedef struct packed {
		logic prox_event_flag;
		logic [1:0] prox_persistence;
		logic spare;
		logic light_event_flag;
		logic [1:0] light_persistence;
		logic combine_and;
	} lps_int_s;
	typedef struct packed {
		logic prox_enable;
		logic [2:0] prox_sleep_select;
		logic emitter_drive_select;
		logic light_enable;
		logic [2:0] light_range_select;
	} lps_sense_s;
endpackage : lps_pkg

/* File: src/lps_regs.sv */
// Purpose: I2C-reached register bank, measurement pacing and interrupt logic.
// Assumes: Sensor samples are valid in the core clock domain at all times.
// Notes: The serial clock only shifts bits in; protocol decode runs on the core clock.

module lps_persist #(
	parameter int W = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic done,
	input wire logic [W-1:0] sample,
	input wire logic [W-1:0] lo,
	input wire logic [W-1:0] hi,
	input wire logic [1:0] sel,
	input wire logic every,
	output logic trip
);
	import lps_pkg::*;
	logic [4:0] cnt_q;
	logic [4:0] need;
	logic outside;

	if (W < 1) begin : g_chk
		$error("Sample width must be at least one bit.");
	end

	always_comb begin
		outside = (sample < lo) || (sample > hi); // [RULE16]
		case (sel) // [RULE9] [RULE11]
			2'b00: need = PERS_ONE;
			2'b01: need = PERS_FOUR;
			2'b10: need = PERS_EIGHT;
			default: need = PERS_MAX;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (done) begin
			if (!outside) begin
				cnt_q <= '0; // [RULE18]
			end else if (cnt_q < PERS_MAX) begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	assign trip = done && ((every && sel == 2'b00) || (outside && cnt_q + 5'h01 >= need));
endmodule : lps_persist

// Notes on behaviour
// RULE1: Control, thresholds and results are byte registers reached over I2C.
// RULE2: Offset zero returns a fixed identification code; writes leave it unchanged.
// RULE3: Proximity enable bit runs continuous measurements; first result after 0.54 ms.
// RULE4: Sleep field picks idle time between emitter pulses, none up to 800 ms.
// RULE5: Configuration bit 3 picks 100 mA or 200 mA emitter sink drive.
// RULE6: Light enable runs continuous conversions with a new result every 100 ms.
// RULE7: Host writes zero to unused configuration and interrupt bits.
// RULE8: Proximity flag sets on an event and holds until host writes zero.
// RULE9: Proximity persistence needs one, four, eight or sixteen tripping conversions.
// RULE10: Light flag sets on an event and holds until host writes zero.
// RULE11: Light persistence: every cycle, or four, eight, sixteen outside conversions.
// RULE12: Combine bit chooses OR or AND of flags for the low interrupt.
// RULE13: Offsets 3 to 7 hold proximity bytes and split 12-bit light limits.
// RULE14: Offsets 8 to 10 hold read-only proximity and 12-bit light results.
// RULE15: Range field selects 800, 400, 200, 100 or 50 lux full scale.
// RULE16: A conversion trips when below its low limit or above its high limit.
// RULE17: The device answers only the fixed 7-bit target address 0x44.
// RULE18: Any in-window conversion returns its persistence counter to zero.
// RULE19: Writing one to a flag leaves it; other fields take written values.
module lps_regs #(
	parameter lps_pkg::lps_byte_t ID_CODE = 8'h5A, // Arbitrary value.
	parameter int PROX_MEAS_CYC_P = lps_pkg::PROX_MEAS_CYC,
	parameter int SLEEP_TICK_CYC_P = lps_pkg::SLEEP_TICK_CYC,
	parameter int LIGHT_CYC_P = lps_pkg::LIGHT_PERIOD_CYC
) (
	// Core clock and reset
	input wire logic clock,
	input wire logic rst,
	// I2C link
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Sensor front end
	input wire logic [7:0] prox_sample,
	input wire logic [11:0] light_sample,
	output lps_pkg::lps_sense_s sense_ctl,
	output logic prox_measure,
	// Interrupt
	output logic irq_out_n
);
	import lps_pkg::*;

	typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_PTR, PH_WR, PH_RD} lps_phase_e;
	typedef enum logic [1:0] {SEQ_OFF, SEQ_MEAS, SEQ_NAP} lps_seq_e;

	if (PROX_MEAS_CYC_P < 1 || SLEEP_TICK_CYC_P < 1 || LIGHT_CYC_P < 1) begin : g_chk
		$error("Timing counts must be at least one cycle.");
	end

	lps_byte_t link_sh_q;
	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	logic rise, fall, start, stop, wr_en;
	lps_phase_e phase_q;
	logic [3:0] bits_q;
	lps_byte_t ptr_q, tx_q, rd_byte, wdata;
	logic sda_oe_n_q, sda_out_q, irq_q;
	lps_cfg_s cfg_q;
	lps_int_s int_q, wint;
	lps_byte_t plo_q, phi_q, llo_q, lmid_q, lhi_q, prox_result_q;
	logic [11:0] light_result_q;
	logic [2:0] range_q;
	lps_seq_e seq_q;
	logic [31:0] pcnt_q, lcnt_q;
	logic [6:0] nap_q, nap_need;
	logic meas_q, prox_done_q, light_done_q, prox_trip, light_trip, wr_int;

	// Bits shift in on the serial clock; the byte is read only while the clock
	// is known low, so it is stable for many core cycles when sampled.
	always_ff @(posedge scl) begin
		link_sh_q <= {link_sh_q[6:0], sda_in};
	end

	always_ff @(posedge clock) begin
		scl_m_q <= scl;
		scl_s_q <= scl_m_q;
		scl_p_q <= scl_s_q;
		sda_m_q <= sda_in;
		sda_s_q <= sda_m_q;
		sda_p_q <= sda_s_q;
	end

	assign rise = scl_s_q && !scl_p_q;
	assign fall = !scl_s_q && scl_p_q;
	assign start = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
	assign stop = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
	assign wdata = link_sh_q;
	assign wr_en = fall && bits_q == 4'h8 && phase_q == PH_WR; // [RULE1]
	assign wr_int = wr_en && ptr_q == REG_INT;
	assign wint = lps_int_s'(wdata);

	always_ff @(posedge clock) begin
		if (rst) begin
			phase_q <= PH_IDLE;
			bits_q <= '0;
			ptr_q <= '0;
			tx_q <= '0;
			sda_oe_n_q <= 1'b1;
		end else if (start) begin
			phase_q <= PH_ADDR;
			bits_q <= '0;
			sda_oe_n_q <= 1'b1;
		end else if (stop) begin
			phase_q <= PH_IDLE;
			sda_oe_n_q <= 1'b1;
		end else if (phase_q != PH_IDLE) begin
			if (rise) begin
				bits_q <= bits_q + 4'h1;
				if (phase_q == PH_RD && bits_q == 4'h8 && sda_s_q) begin
					phase_q <= PH_IDLE; // Host declined further data.
				end
			end else if (fall) begin
				if (bits_q == 4'h8) begin
					sda_oe_n_q <= 1'b0;
					case (phase_q)
						PH_ADDR: begin
							if (link_sh_q[7:1] == I2C_ADDR) begin // [RULE17]
								phase_q <= link_sh_q[0] ? PH_RD : PH_PTR;
							end else begin
								phase_q <= PH_IDLE;
								sda_oe_n_q <= 1'b1;
							end
						end
						PH_PTR: begin
							ptr_q <= link_sh_q;
							phase_q <= PH_WR;
						end
						PH_WR: ptr_q <= ptr_q + 8'h01;
						default: sda_oe_n_q <= 1'b1;
					endcase
				end else if (bits_q == 4'h9) begin
					bits_q <= '0;
					if (phase_q == PH_RD) begin
						sda_oe_n_q <= rd_byte[7];
						tx_q <= {rd_byte[6:0], 1'b1};
						ptr_q <= ptr_q + 8'h01;
					end else begin
						sda_oe_n_q <= 1'b1;
					end
				end else if (phase_q == PH_RD) begin
					sda_oe_n_q <= tx_q[7];
					tx_q <= {tx_q[6:0], 1'b1};
				end
			end
		end
	end

	always_comb begin
		if (ptr_q == REG_ID) begin
			rd_byte = ID_CODE; // [RULE2]
		end else if (ptr_q == REG_CFG) begin
			rd_byte = cfg_q;
		end else if (ptr_q == REG_INT) begin
			rd_byte = int_q;
		end else if (ptr_q == REG_PLO) begin
			rd_byte = plo_q;
		end else if (ptr_q == REG_PHI) begin
			rd_byte = phi_q;
		end else if (ptr_q == REG_LLO) begin
			rd_byte = llo_q;
		end else if (ptr_q == REG_LMID) begin
			rd_byte = lmid_q;
		end else if (ptr_q == REG_LHI) begin
			rd_byte = lhi_q;
		end else if (ptr_q == REG_PRES) begin
			rd_byte = prox_result_q; // [RULE14]
		end else if (ptr_q == REG_LRLO) begin
			rd_byte = light_result_q[7:0];
		end else if (ptr_q == REG_LRHI) begin
			rd_byte = {4'h0, light_result_q[11:8]};
		end else if (ptr_q == REG_RANGE) begin
			rd_byte = {5'h00, range_q};
		end else begin
			rd_byte = 8'h00;
		end
	end

	// Identification and result offsets have no write path at all.
	always_ff @(posedge clock) begin
		if (rst) begin
			cfg_q <= RST_CFG;
			plo_q <= RST_PLO;
			phi_q <= RST_PHI;
			llo_q <= RST_LLO;
			lmid_q <= RST_LMID;
			lhi_q <= RST_LHI;
			range_q <= RST_RANGE;
		end else if (wr_en) begin
			if (ptr_q == REG_CFG) begin
				cfg_q <= wdata; // [RULE3] [RULE4] [RULE5] [RULE6]
			end else if (ptr_q == REG_PLO) begin
				plo_q <= wdata; // [RULE13]
			end else if (ptr_q == REG_PHI) begin
				phi_q <= wdata;
			end else if (ptr_q == REG_LLO) begin
				llo_q <= wdata;
			end else if (ptr_q == REG_LMID) begin
				lmid_q <= wdata;
			end else if (ptr_q == REG_LHI) begin
				lhi_q <= wdata;
			end else if (ptr_q == REG_RANGE) begin
				range_q <= wdata[2:0]; // [RULE15]
			end
		end
	end

	// A flag set by hardware in the same cycle as a clearing write stays set.
	always_ff @(posedge clock) begin
		if (rst) begin
			int_q <= RST_INT;
		end else begin
			if (wr_int) begin
				int_q.prox_persistence <= wint.prox_persistence; // [RULE19]
				int_q.light_persistence <= wint.light_persistence;
				int_q.combine_and <= wint.combine_and;
			end
			int_q.spare <= 1'b0;
			if (prox_trip) begin
				int_q.prox_event_flag <= 1'b1; // [RULE8]
			end else if (wr_int && !wdata[INT_PFLAG]) begin
				int_q.prox_event_flag <= 1'b0;
			end
			if (light_trip) begin
				int_q.light_event_flag <= 1'b1; // [RULE10]
			end else if (wr_int && !wdata[INT_LFLAG]) begin
				int_q.light_event_flag <= 1'b0;
			end
		end
	end

	always_comb begin
		case (cfg_q.prox_sleep_select) // [RULE4]
			3'b111: nap_need = 7'h00;
			3'b110: nap_need = 7'h01;
			3'b101: nap_need = 7'h04;
			3'b100: nap_need = 7'h06;
			3'b011: nap_need = 7'h08;
			3'b010: nap_need = 7'h10;
			3'b001: nap_need = 7'h20;
			default: nap_need = 7'h40;
		endcase
	end

	always_ff @(posedge clock) begin
		prox_done_q <= 1'b0;
		if (rst) begin
			seq_q <= SEQ_OFF;
			pcnt_q <= '0;
			nap_q <= '0;
			meas_q <= 1'b0;
			prox_result_q <= '0;
		end else if (!cfg_q.prox_enable) begin
			seq_q <= SEQ_OFF; // [RULE3]
			pcnt_q <= '0;
			nap_q <= '0;
			meas_q <= 1'b0;
		end else begin
			case (seq_q)
				SEQ_OFF: begin
					seq_q <= SEQ_MEAS;
					meas_q <= 1'b1;
					pcnt_q <= '0;
				end
				SEQ_MEAS: begin
					if (pcnt_q == 32'(PROX_MEAS_CYC_P - 1)) begin
						prox_result_q <= prox_sample; // [RULE3]
						prox_done_q <= 1'b1;
						pcnt_q <= '0;
						if (nap_need != 7'h00) begin
							seq_q <= SEQ_NAP;
							meas_q <= 1'b0;
						end
					end else begin
						pcnt_q <= pcnt_q + 32'h1;
					end
				end
				default: begin
					if (pcnt_q == 32'(SLEEP_TICK_CYC_P - 1)) begin
						pcnt_q <= '0;
						if (nap_q + 7'h01 >= nap_need) begin // [RULE4]
							nap_q <= '0;
							seq_q <= SEQ_MEAS;
							meas_q <= 1'b1;
						end else begin
							nap_q <= nap_q + 7'h01;
						end
					end else begin
						pcnt_q <= pcnt_q + 32'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		light_done_q <= 1'b0;
		if (rst) begin
			lcnt_q <= '0;
			light_result_q <= '0;
		end else if (!cfg_q.light_enable) begin
			lcnt_q <= '0;
		end else if (lcnt_q == 32'(LIGHT_CYC_P - 1)) begin
			lcnt_q <= '0; // [RULE6]
			light_done_q <= 1'b1;
			light_result_q <= light_sample;
		end else begin
			lcnt_q <= lcnt_q + 32'h1;
		end
	end

	lps_persist #(.W(8)) u_prox_pers ( // [RULE9] [RULE16] [RULE18]
		.clock(clock),
		.rst(rst),
		.done(prox_done_q),
		.sample(prox_result_q),
		.lo(plo_q),
		.hi(phi_q),
		.sel(int_q.prox_persistence),
		.every(1'b0),
		.trip(prox_trip)
	);

	lps_persist #(.W(12)) u_light_pers ( // [RULE11] [RULE16] [RULE18]
		.clock(clock),
		.rst(rst),
		.done(light_done_q),
		.sample(light_result_q),
		.lo({lmid_q[3:0], llo_q}),
		.hi({lhi_q, lmid_q[7:4]}),
		.sel(int_q.light_persistence),
		.every(1'b1),
		.trip(light_trip)
	);

	always_ff @(posedge clock) begin
		sda_out_q <= 1'b0;
		if (rst) begin
			irq_q <= 1'b1;
		end else if (int_q.combine_and) begin
			irq_q <= !(int_q.prox_event_flag && int_q.light_event_flag); // [RULE12]
		end else begin
			irq_q <= !(int_q.prox_event_flag || int_q.light_event_flag);
		end
	end

	assign sda_out = sda_out_q;
	assign sda_oe_n = sda_oe_n_q;
	assign irq_out_n = irq_q;
	assign prox_measure = meas_q;
	assign sense_ctl = {cfg_q.prox_enable, cfg_q.prox_sleep_select,
		cfg_q.emitter_drive_select, cfg_q.light_enable, range_q}; // [RULE5]

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_prox_flag_hold: assert property ( // [RULE8]
		int_q.prox_event_flag && !(wr_int && !wdata[INT_PFLAG]) |=> int_q.prox_event_flag
	) else $error("Proximity flag dropped without a clearing write.");
	a_light_flag_hold: assert property ( // [RULE10]
		int_q.light_event_flag && !(wr_int && !wdata[INT_LFLAG]) |=> int_q.light_event_flag
	) else $error("Light flag dropped without a clearing write.");
	a_flag_set_wins: assert property ( // [RULE19]
		prox_trip && wr_int |=> int_q.prox_event_flag
	) else $error("Clearing write beat a proximity event.");
	a_irq_either: assert property ( // [RULE12]
		!int_q.combine_and && (int_q.prox_event_flag || int_q.light_event_flag) |=> !irq_out_n
	) else $error("Interrupt not asserted in OR mode.");
	a_irq_both: assert property ( // [RULE12]
		int_q.combine_and && !(int_q.prox_event_flag && int_q.light_event_flag) |=> irq_out_n
	) else $error("Interrupt asserted in AND mode with one flag.");
	a_prox_start: assert property ( // [RULE3]
		$rose(cfg_q.prox_enable) |-> ##2 prox_measure
	) else $error("Proximity measurement did not start after enable.");
	a_prox_latch: assert property ( // [RULE3]
		prox_done_q |-> prox_result_q == $past(prox_sample)
	) else $error("Proximity result not taken at end of measurement.");
	a_light_quiet: assert property ( // [RULE6]
		!cfg_q.light_enable |=> !light_done_q
	) else $error("Light conversion completed while disabled.");
	a_cfg_write: assert property ( // [RULE1]
		wr_en && ptr_q == REG_CFG |=> cfg_q == $past(wdata)
	) else $error("Configuration write not stored.");

	c_prox_trip: cover property (prox_trip);
	c_light_trip: cover property (light_trip);
	c_irq_low: cover property ($fell(irq_out_n));
	c_read_phase: cover property (phase_q == PH_RD && fall);
endmodule : lps_regs

/* File: verification/lps_host.sv */
// Purpose: Behavioural serial host that reaches the register bank over its two-wire link.
// Assumes: The data line has a pull-up; the host only pulls it low or lets it go.
// Notes: The serial clock stands high between frames and is timed in 80 ns steps.
module lps_host (
	// Serial link
	output logic scl,
	output logic drv_low,
	input wire logic sda,
	// Read results and write acknowledge
	output logic rd_valid,
	output lps_pkg::lps_byte_t rd_data,
	output logic ack_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	import lps_pkg::*;

	initial begin
		scl = 1'b1;
		drv_low = 1'b0;
		rd_valid = 1'b0;
		rd_data = 8'h00;
		ack_ok = 1'b0;
	end

	// A 320 ns low phase covers the 200 ns minimum plus the core's resync lag.
	task automatic bit_io(input logic b, output logic r);
		#80 drv_low = ~b;
		#240 scl = 1'b1;
		#80 r = sda;
		#80 scl = 1'b0;
	endtask : bit_io

	task automatic start();
		#80 drv_low = 1'b0;
		#240 scl = 1'b1;
		#240 drv_low = 1'b1;
		#240 scl = 1'b0;
	endtask : start

	task automatic stop();
		#80 drv_low = 1'b1;
		#240 scl = 1'b1;
		#240 drv_low = 1'b0;
		#240;
	endtask : stop

	task automatic put_byte(input lps_byte_t b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : put_byte

	task automatic wr(input logic [6:0] a, input lps_byte_t p, input lps_byte_t d[$]);
		logic k;
		start();
		put_byte({a, 1'b0}, k);
		ack_ok = k;
		if (k) begin
			put_byte(p, k);
			foreach (d[i]) begin
				put_byte(d[i], k);
			end
		end
		stop();
	endtask : wr

	task automatic rd(input lps_byte_t p, input int n);
		logic k;
		lps_byte_t b;
		start();
		put_byte({I2C_ADDR, 1'b0}, k);
		put_byte(p, k);
		start();
		put_byte({I2C_ADDR, 1'b1}, k);
		for (int i = 0; i < n; i++) begin
			for (int j = 7; j >= 0; j--) begin
				bit_io(1'b1, b[j]);
			end
			// The last byte is refused so the device lets go of the line.
			bit_io(i == n - 1, k);
			rd_data = b;
			rd_valid = 1'b1;
			#1 rd_valid = 1'b0;
		end
		stop();
	endtask : rd
endmodule : lps_host

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the light and proximity register bank.
// Assumes: Shortened pacing counts; registers reached over the serial link only.
// Notes: Read bytes are checked against a queue of expected values.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lps_pkg::*;
	localparam lps_byte_t ID_EXP = 8'hC3; // Arbitrary value.
	logic clock, rst, scl, drv_low, sda, sda_out, sda_oe_n, prox_measure, irq_out_n;
	logic rd_valid, ack_ok;
	lps_byte_t rd_data, prox_sample, e;
	logic [11:0] light_sample;
	lps_sense_s sense_ctl;
	lps_byte_t exp_q[$];
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [31:0] lf = 32'hF6DC;

	// Open-drain wire with pull-up: low whenever either party pulls.
	assign sda = (drv_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	lps_regs #(.ID_CODE(ID_EXP), .PROX_MEAS_CYC_P(20), .SLEEP_TICK_CYC_P(10), .LIGHT_CYC_P(50))
	lps_regs_inst (.clock(clock), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .prox_sample(prox_sample), .light_sample(light_sample),
		.sense_ctl(sense_ctl), .prox_measure(prox_measure), .irq_out_n(irq_out_n));
	lps_host lps_host_inst (.scl(scl), .drv_low(drv_low), .sda(sda), .rd_valid(rd_valid),
		.rd_data(rd_data), .ack_ok(ack_ok));

	always @(posedge rd_valid) begin
		e = 'x;
		if (exp_q.size() > 0) begin
			e = exp_q.pop_front();
		end
		`CHK(rd_data, e)
	end

	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			end_of_test();
		end
	end

	function automatic lps_byte_t rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[7:0];
	endfunction : rnd

	task automatic wr(input lps_byte_t p, input lps_byte_t d[$]);
		lps_host_inst.wr(I2C_ADDR, p, d);
		`CHK(ack_ok, 1'b1)
	endtask : wr

	task automatic rd(input lps_byte_t p, input lps_byte_t x[$]);
		exp_q = {exp_q, x};
		lps_host_inst.rd(p, x.size());
	endtask : rd

	// The value set at one window's end is the one measured by the next window.
	task automatic conv(input lps_byte_t s, input int n);
		repeat (n) begin
			@(negedge prox_measure);
			prox_sample <= s;
		end
	endtask : conv

	task automatic irq_is(input logic v);
		repeat (3) @(posedge clock);
		`CHK(irq_out_n, v)
	endtask : irq_is

	task automatic end_of_test();
		if (err_total == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		logic [2:0] r;
		lps_byte_t c;
		lps_byte_t t[$];
		rst = 1'b1;
		prox_sample = 8'h60;
		light_sample = 12'h400;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		`CHK(sense_ctl, 9'h178)
		irq_is(1'b0);
		rd(REG_ID, {ID_EXP, RST_CFG, RST_INT, RST_PLO, RST_PHI, RST_LLO, RST_LMID, RST_LHI});
		rd(REG_PRES, {8'h60, 8'h00, 8'h04, 8'h00});
		lps_host_inst.wr(7'h45, REG_CFG, {8'h00});
		`CHK(ack_ok, 1'b0)
		`CHK(sense_ctl, 9'h178)
		wr(REG_ID, {8'h00});
		wr(REG_PRES, {8'h11});
		wr(8'h0C, {8'h5A});
		rd(REG_ID, {ID_EXP});
		rd(REG_PRES, {8'h60});
		rd(8'h0C, {8'h00});
		t = {rnd(), rnd(), rnd(), rnd(), rnd()};
		wr(REG_PLO, t);
		rd(REG_PLO, t);
		for (int s = 0; s < 8; s++) begin
			r = 3'(s);
			c = {1'b0, r, r[0], 1'b0, 2'b00};
			wr(REG_CFG, {c});
			rd(REG_CFG, {c});
			c = {5'h00, r};
			wr(REG_RANGE, {c});
			rd(REG_RANGE, {c});
			`CHK(sense_ctl, {1'b0, r, r[0], 1'b0, r})
			`CHK(sense_ctl.light_range_select, r)
		end
		wr(REG_PLO, {8'h40, 8'h80});
		wr(REG_CFG, {8'hE0});
		wr(REG_INT, {8'h20});
		irq_is(1'b1);
		conv(8'hC0, 3);
		conv(8'h60, 1);
		irq_is(1'b1);
		conv(8'hC0, 2);
		irq_is(1'b1);
		conv(8'h10, 2);
		conv(8'h60, 1);
		irq_is(1'b0);
		rd(REG_INT, {8'hA0});
		wr(REG_INT, {8'hA1});
		irq_is(1'b1);
		rd(REG_INT, {8'hA1});
		wr(REG_LLO, {8'h00, 8'h21, 8'h80});
		wr(REG_CFG, {8'hE4});
		repeat (60) @(posedge clock);
		irq_is(1'b0);
		rd(REG_LRLO, {8'h00, 8'h04});
		wr(REG_INT, {8'h22});
		repeat (250) @(posedge clock);
		irq_is(1'b1);
		light_sample <= 12'h900;
		repeat (140) @(posedge clock);
		irq_is(1'b1);
		repeat (100) @(posedge clock);
		irq_is(1'b0);
		end_of_test();
	end
endmodule : tb
